// ---- tps_pkg.sv ----
// Purpose: shared constants and types of the timer pwm / capture subsystem
// Assumes: one subsystem, registers reached over apb with 32-bit data
// Notes:   register data sits in the low bits, upper bits read as zero

package tps_pkg;

	// =====================================================================
	// modes and register layouts
	typedef enum logic [1:0] {
		TPS_LOW_POWER = 2'b00,
		TPS_DUAL8     = 2'b01,
		TPS_PWM16     = 2'b10,
		TPS_CAPTURE   = 2'b11
	} tps_sub_mode_t;

	typedef struct packed {
		tps_sub_mode_t sel;
		logic          run_hi;
		logic          run_lo;
	} tps_mode_t;

	typedef struct packed {
		logic       pol;
		logic [2:0] edg;
	} tps_pin_ctl_t;

	typedef struct packed {
		tps_pin_ctl_t pin1;
		tps_pin_ctl_t pin0;
	} tps_io_ctl_t;

	// =====================================================================
	// register indices, byte address is four times the index
	localparam logic [2:0] TPS_IDX_MODE    = 3'h0;
	localparam logic [2:0] TPS_IDX_IO_CTL  = 3'h1;
	localparam logic [2:0] TPS_IDX_IRQ_EN  = 3'h2;
	localparam logic [2:0] TPS_IDX_IRQ_PND = 3'h3;
	localparam logic [2:0] TPS_IDX_PSC     = 3'h4;
	localparam logic [2:0] TPS_IDX_CNT     = 3'h5;
	localparam logic [2:0] TPS_IDX_PER     = 3'h6;
	localparam logic [2:0] TPS_IDX_DTY     = 3'h7;

	// =====================================================================
	// reset values
	localparam logic [3:0]  TPS_MODE_RST = 4'h0;
	localparam logic [7:0]  TPS_IO_RST   = 8'h00;
	localparam logic [3:0]  TPS_IRQ_RST  = 4'h0;
	localparam logic [7:0]  TPS_PSC_RST  = 8'h00;
	localparam logic [15:0] TPS_CNT_RST  = 16'h0000;

	// =====================================================================
	// capture edge codes
	localparam logic [2:0] TPS_EDG_RISE       = 3'h0;
	localparam logic [2:0] TPS_EDG_FALL       = 3'h1;
	localparam logic [2:0] TPS_EDG_RISE_CLR   = 3'h2;
	localparam logic [2:0] TPS_EDG_FALL_CLR   = 3'h3;
	localparam logic [2:0] TPS_EDG_BOTH       = 3'h4;
	localparam logic [2:0] TPS_EDG_BOTH_CLR_R = 3'h5;
	localparam logic [2:0] TPS_EDG_BOTH_CLR_F = 3'h6;
	localparam logic [2:0] TPS_EDG_BOTH_CLR_B = 3'h7;

	// pending bit positions
	localparam int TPS_PND_A = 0;
	localparam int TPS_PND_B = 1;
	localparam int TPS_PND_C = 2;
	localparam int TPS_PND_D = 3;

endpackage : tps_pkg

// ---- tps_edge.sv ----
// Purpose: capture edge detector and counter clear request for one pin
// Assumes: pin input already synchronous to clk
// Notes:   outputs are one-cycle pulses, gated by enable

`timescale 1ns/1ns
`default_nettype none

module tps_edge
	import tps_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// pin and configuration
	input  wire logic       pin_in,
	input  wire logic       enable,
	input  wire logic [2:0] edg,
	// events
	output logic            capture,
	output logic            clear_cnt
);

	logic prev;
	wire  rise = enable & pin_in & ~prev;
	wire  fall = enable & ~pin_in & prev;

	always_ff @(posedge clk) begin
		if (rst) begin
			prev <= 1'b0;
		end else begin
			prev <= pin_in;
		end
	end

	// =====================================================================
	// edge code decode
	assign capture = edg[2] ? (rise | fall) : (edg[0] ? fall : rise);
	assign clear_cnt = (((edg == TPS_EDG_RISE_CLR) | (edg == TPS_EDG_BOTH_CLR_R)) & rise)
		| (((edg == TPS_EDG_FALL_CLR) | (edg == TPS_EDG_BOTH_CLR_F)) & fall)
		| ((edg == TPS_EDG_BOTH_CLR_B) & (rise | fall));

	both_clear_a: assert property (@(posedge clk) disable iff (rst)
		(enable && !$past(rst) && edg == TPS_EDG_BOTH_CLR_B && pin_in != $past(pin_in))
		|-> (capture && clear_cnt))
		else $error("both-edge code missed capture or clear");

endmodule : tps_edge

`default_nettype wire

// ---- tps_wave.sv ----
// Purpose: pwm output level of one channel from counter compare events
// Assumes: tick is the counter increment enable of this channel
// Notes:   output is registered behind the act flag, so it trails the compare by two clocks

`timescale 1ns/1ns
`default_nettype none

module tps_wave (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// compare inputs
	input  wire logic run,
	input  wire logic tick,
	input  wire logic at_zero,
	input  wire logic duty_match,
	input  wire logic duty_zero,
	input  wire logic pol,
	// pin level
	output logic      pin_out
);

	logic act;

	// active phase starts at the 00 to 01 step, ends one step after duty match
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			act <= 1'b0;
		end else if (tick && duty_match) begin
			act <= 1'b0;
		end else if (tick && at_zero && !duty_zero) begin
			act <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_out <= 1'b0;
		end else begin
			pin_out <= (run && act && !duty_zero) ? ~pol : pol;
		end
	end

	duty_zero_a: assert property (@(posedge clk) disable iff (rst)
		(run && duty_zero) |=> (pin_out == $past(pol)))
		else $error("zero duty did not hold default level");

endmodule : tps_wave

`default_nettype wire

// ---- tps_timer.sv ----
// Purpose: one timer subsystem: prescaler, 16-bit counter, period/duty or
//          capture registers, two timer pins, four pending sources, apb slave
// Assumes: 25 MHz clk, synchronous active-high rst, pins synchronous to clk
// Notes:   apb answers with no wait state; read data is taken in setup

`timescale 1ns/1ns
`default_nettype none

module tps_timer
	import tps_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// timer pins
	input  wire logic [1:0]  timer_pin_in,
	output logic [1:0]       timer_pin_out,
	output logic [1:0]       timer_pin_oe_n,
	// interrupt request
	output logic             irq
);

	// =====================================================================
	// registers
	tps_mode_t   mode;
	tps_io_ctl_t io_ctl;
	logic [3:0]  irq_enable_reg;
	logic [3:0]  irq_pending_reg;
	logic [7:0]  prescale_field;
	logic [7:0]  psc;
	logic [15:0] subsystem_counter_reg;
	logic [15:0] period_capture_reg;
	logic [15:0] duty_capture_reg;
	logic [15:0] per_act;
	logic [15:0] dty_act;
	logic [15:0] next_cnt;
	logic [7:0]  next_psc;
	logic [3:0]  next_pend;

	// =====================================================================
	// mode decode
	wire lp       = (mode.sel == TPS_LOW_POWER);
	wire dual8    = (mode.sel == TPS_DUAL8);
	wire pwm16    = (mode.sel == TPS_PWM16);
	wire capm     = (mode.sel == TPS_CAPTURE);
	wire pwm_mode = dual8 | pwm16;
	wire any_run  = mode.run_lo | mode.run_hi;

	wire [1:0] ch_run;
	assign ch_run[0] = !lp && mode.run_lo;
	assign ch_run[1] = !lp && (dual8 ? mode.run_hi : mode.run_lo);

	wire psc_run = !lp && (dual8 ? any_run : mode.run_lo);
	wire tick    = psc_run && (psc == prescale_field);

	// =====================================================================
	// apb decode
	wire [2:0] idx     = paddr[4:2];
	wire       addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0);
	wire       apb_acc = psel && penable;
	wire       apb_rd  = psel && !penable && !pwrite;
	wire       wr      = apb_acc && pwrite && addr_ok;
	wire       wr_mode = wr && (idx == TPS_IDX_MODE);
	wire       wr_io   = wr && (idx == TPS_IDX_IO_CTL);
	wire       wr_en   = wr && (idx == TPS_IDX_IRQ_EN);
	wire       wr_pend = wr && (idx == TPS_IDX_IRQ_PND);
	wire       wr_psc  = wr && (idx == TPS_IDX_PSC);
	wire       wr_cnt  = wr && (idx == TPS_IDX_CNT);
	wire       wr_per  = wr && (idx == TPS_IDX_PER) && !lp;
	wire       wr_dty  = wr && (idx == TPS_IDX_DTY) && !lp;

	assign pready  = 1'b1;
	assign pslverr = apb_acc && !addr_ok;

	wire [31:0] rd_data =
		!addr_ok                 ? 32'h0000_0000 :
		(idx == TPS_IDX_MODE)    ? {28'h000_0000, mode} :
		(idx == TPS_IDX_IO_CTL)  ? {24'h00_0000, io_ctl} :
		(idx == TPS_IDX_IRQ_EN)  ? {28'h000_0000, irq_enable_reg} :
		(idx == TPS_IDX_IRQ_PND) ? {28'h000_0000, irq_pending_reg} :
		(idx == TPS_IDX_PSC)     ? {24'h00_0000, prescale_field} :
		(idx == TPS_IDX_CNT)     ? {16'h0000, subsystem_counter_reg} :
		(idx == TPS_IDX_PER)     ? {16'h0000, period_capture_reg} :
		{16'h0000, duty_capture_reg};

	// =====================================================================
	// per-channel compare, capture and pin logic
	wire [1:0] ch_tick;
	wire [1:0] ch_zero;
	wire [1:0] ch_dmatch;
	wire [1:0] ch_pmatch;
	wire [1:0] ch_dzero;
	wire [1:0] upd;
	wire [1:0] cap_ev;
	wire [1:0] cap_rst;
	wire [7:0] next_lane [2];

	wire eq_p16   = (subsystem_counter_reg == per_act);
	wire eq_d16   = (subsystem_counter_reg == dty_act);
	wire cnt_max  = (subsystem_counter_reg == 16'hFFFF);
	wire cap_en   = capm && ch_run[0];
	wire cap_clr  = |cap_rst;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			wire [7:0] lane = subsystem_counter_reg[8*i +: 8];

			assign ch_tick[i]   = tick && ch_run[i];
			assign ch_zero[i]   = dual8 ? (lane == 8'h00) : (subsystem_counter_reg == 16'h0000);
			assign ch_dmatch[i] = dual8 ? (lane == dty_act[8*i +: 8]) : eq_d16;
			assign ch_pmatch[i] = dual8 ? (lane == per_act[8*i +: 8]) : eq_p16;
			assign ch_dzero[i]  = dual8 ? (dty_act[8*i +: 8] == 8'h00) : (dty_act == 16'h0000);
			// 8-bit lane wraps through FFh when preset above period
			assign next_lane[i] = ch_pmatch[i] ? 8'h00 : 8'(lane + 8'h01);

			// in pwm modes buffered values load at old period match or while stopped, in other modes every cycle
			assign upd[i] = pwm_mode ? (!ch_run[i] || (ch_tick[i] && ch_pmatch[i])) : 1'b1;

			always_ff @(posedge clk) begin
				if (rst) begin
					per_act[8*i +: 8] <= 8'h00;
					dty_act[8*i +: 8] <= 8'h00;
				end else if (upd[i]) begin
					per_act[8*i +: 8] <= period_capture_reg[8*i +: 8];
					dty_act[8*i +: 8] <= duty_capture_reg[8*i +: 8];
				end
			end

			tps_wave u_wave (
				.clk        (clk),
				.rst        (rst),
				.run        (pwm_mode && ch_run[i]),
				.tick       (ch_tick[i]),
				.at_zero    (ch_zero[i]),
				.duty_match (ch_dmatch[i]),
				.duty_zero  (ch_dzero[i]),
				.pol        (i == 0 ? io_ctl.pin0.pol : io_ctl.pin1.pol),
				.pin_out    (timer_pin_out[i])
			);

			tps_edge u_edge (
				.clk       (clk),
				.rst       (rst),
				.pin_in    (timer_pin_in[i]),
				.enable    (cap_en),
				.edg       (i == 0 ? io_ctl.pin0.edg : io_ctl.pin1.edg),
				.capture   (cap_ev[i]),
				.clear_cnt (cap_rst[i])
			);
		end
	endgenerate

	// =====================================================================
	// counter and prescaler
	always_comb begin
		next_cnt = subsystem_counter_reg;
		if (lp) begin
			next_cnt = subsystem_counter_reg;
		end else if (capm) begin
			if (cap_clr) begin
				next_cnt = 16'h0000;
			end else if (ch_tick[0]) begin
				next_cnt = 16'(subsystem_counter_reg + 16'h0001);
			end
		end else if (dual8) begin
			next_cnt[7:0]  = ch_tick[0] ? next_lane[0] : subsystem_counter_reg[7:0];
			next_cnt[15:8] = ch_tick[1] ? next_lane[1] : subsystem_counter_reg[15:8];
		end else if (ch_tick[0]) begin
			next_cnt = eq_p16 ? 16'h0000 : 16'(subsystem_counter_reg + 16'h0001);
		end
		if (wr_cnt && !any_run && !lp) begin
			next_cnt = pwdata[15:0];
		end
	end

	always_comb begin
		next_psc = psc;
		if (lp) begin
			next_psc = psc;
		end else if (!psc_run || cap_clr || tick) begin
			next_psc = 8'h00;
		end else begin
			next_psc = 8'(psc + 8'h01);
		end
	end

	// =====================================================================
	// pending sources, set wins over a clear in the same cycle
	wire [3:0] ev;
	assign ev[TPS_PND_A] = capm ? cap_ev[0] : (pwm_mode && ch_tick[0] && ch_dmatch[0]);
	assign ev[TPS_PND_B] = capm ? cap_ev[1] : (pwm_mode && ch_tick[0] && ch_pmatch[0]);
	assign ev[TPS_PND_C] = capm ? (ch_tick[0] && cnt_max && !cap_clr)
		: (dual8 && ch_tick[1] && ch_dmatch[1]);
	assign ev[TPS_PND_D] = dual8 && ch_tick[1] && ch_pmatch[1];

	wire [3:0] pend_clr = (wr_pend && !lp) ? pwdata[3:0] : 4'h0;
	assign next_pend = (irq_pending_reg & ~pend_clr) | ev;

	// =====================================================================
	// register update
	always_ff @(posedge clk) begin
		if (rst) begin
			mode           <= tps_mode_t'(TPS_MODE_RST);
			io_ctl         <= tps_io_ctl_t'(TPS_IO_RST);
			irq_enable_reg <= TPS_IRQ_RST;
			prescale_field <= TPS_PSC_RST;
		end else begin
			if (wr_mode) mode <= tps_mode_t'(pwdata[3:0]);
			if (wr_io) io_ctl <= tps_io_ctl_t'(pwdata[7:0]);
			if (wr_en) irq_enable_reg <= pwdata[3:0];
			if (wr_psc) prescale_field <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			subsystem_counter_reg <= TPS_CNT_RST;
			psc                   <= TPS_PSC_RST;
			irq_pending_reg       <= TPS_IRQ_RST;
		end else begin
			subsystem_counter_reg <= next_cnt;
			psc                   <= next_psc;
			irq_pending_reg       <= next_pend;
		end
	end

	// capture takes priority over a software write in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			period_capture_reg <= TPS_CNT_RST;
			duty_capture_reg   <= TPS_CNT_RST;
		end else begin
			if (cap_ev[0]) period_capture_reg <= subsystem_counter_reg;
			else if (wr_per) period_capture_reg <= pwdata[15:0];
			if (cap_ev[1]) duty_capture_reg <= subsystem_counter_reg;
			else if (wr_dty) duty_capture_reg <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata         <= 32'h0000_0000;
			irq            <= 1'b0;
			timer_pin_oe_n <= 2'b11;
		end else begin
			if (apb_rd) prdata <= rd_data;
			irq            <= |(irq_pending_reg & irq_enable_reg);
			timer_pin_oe_n <= {2{~pwm_mode}};
		end
	end

	// =====================================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_match16;
		pwm16 && ch_tick[0] && eq_p16;
	endsequence
	sequence s_match_lo;
		dual8 && ch_tick[0] && ch_pmatch[0] && !wr_cnt;
	endsequence
	property p_wrap16;
		s_match16 |=> (subsystem_counter_reg == 16'h0000);
	endproperty

	wrap_16bit_a: assert property (p_wrap16)
		else $error("16-bit counter did not clear after period match");
	lane_wrap_a: assert property (s_match_lo |=> (subsystem_counter_reg[7:0] == 8'h00))
		else $error("low lane did not clear after period match");
	cnt_write_ign_a: assert property ((wr_cnt && any_run && !ch_tick[0] && !ch_tick[1]
		&& !cap_clr) |=> $stable(subsystem_counter_reg))
		else $error("counter write accepted while running");
	lp_freeze_a: assert property (lp |=> ($stable(subsystem_counter_reg) && $stable(psc)))
		else $error("counter or prescaler moved in low-power mode");
	lp_pend_a: assert property ((lp && wr_pend)
		|=> ((irq_pending_reg & $past(irq_pending_reg)) == $past(irq_pending_reg)))
		else $error("pending bit cleared in low-power mode");
	psc_stop_a: assert property ((!psc_run && !lp) |=> (psc == 8'h00))
		else $error("prescaler not reset when stopped");
	psc_count_a: assert property ((psc_run && !cap_clr && psc != prescale_field)
		|=> (psc == 8'($past(psc) + 8'h01)))
		else $error("prescaler did not advance");
	cap_copy_a: assert property (cap_ev[0] |=> (period_capture_reg == $past(subsystem_counter_reg)))
		else $error("capture did not copy counter");
	pend_set_a: assert property ((ev[TPS_PND_B] && pend_clr[TPS_PND_B]) |=> irq_pending_reg[TPS_PND_B])
		else $error("pending event lost against clear");
	irq_gate_a: assert property ((irq_pending_reg[TPS_PND_A] && irq_enable_reg[TPS_PND_A]) |=> irq)
		else $error("enabled pending bit did not raise irq");
	read_back_a: assert property ((wr_per && !cap_ev[0]) |=> (period_capture_reg == $past(pwdata[15:0])))
		else $error("period register does not hold written value");

endmodule : tps_timer

`default_nettype wire

// ---- tps_pin_model.sv ----
// Purpose: far side of the two timer pins
// Assumes: levels synchronous to clk
// Notes:   an undriven pin carries the bench drive level
`timescale 1ns/1ns
`default_nettype none

module tps_pin_model (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// timer side
	input  wire logic [1:0]       pin_out,
	input  wire logic [1:0]       pin_oe_n,
	output logic [1:0]            pin_lvl,
	// bench side
	input  wire logic [1:0]       drive_lvl,
	output logic [1:0][15:0]      per,
	output logic [1:0][15:0]      high
);
	logic [1:0]       prev;
	logic [1:0][15:0] since;
	logic [1:0][15:0] hcnt;

	// ==========
	// wire level
	assign pin_lvl = (pin_out & ~pin_oe_n) | (drive_lvl & pin_oe_n);

	// ==========
	// rise to rise measure, no glitch filter
	always_ff @(posedge clk) begin
		prev <= pin_lvl;
		for (int i = 0; i < 2; i++) begin
			if (rst) begin
				{per[i], high[i], since[i], hcnt[i]} <= '0;
			end else if (pin_lvl[i] && !prev[i]) begin
				per[i]   <= since[i];
				high[i]  <= hcnt[i];
				since[i] <= 16'h0001;
				hcnt[i]  <= 16'h0001;
			end else begin
				since[i] <= since[i] + 16'h0001;
				hcnt[i]  <= hcnt[i] + {15'h0, pin_lvl[i]};
			end
		end
	end
endmodule : tps_pin_model

`default_nettype wire

// ---- tps_timer_test.sv ----
// Purpose: self-checking bench of the timer subsystem
// Assumes: apb master here, pin model on the far side
// Notes:   short counts keep the run under six hundred clocks
`timescale 1ns/1ns
`default_nettype none

module tps_timer_test
	import tps_pkg::*;
;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic [7:0]       paddr = 8'h00;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [31:0]      pwdata = 32'h0000_0000;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [1:0]       pin_lvl;
	logic [1:0]       pin_out;
	logic [1:0]       pin_oe_n;
	logic [1:0]       drive_lvl = 2'b00;
	logic             irq;
	logic [1:0][15:0] per;
	logic [1:0][15:0] high;
	logic [31:0]      rd;
	logic [31:0]      rd2;
	logic             err;
	int               n_fail = 0;
	int               n_checks = 0;
	int               bad;

	always #20 clk = ~clk;

	tps_timer DUT (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_pin_in(pin_lvl), .timer_pin_out(pin_out),
		.timer_pin_oe_n(pin_oe_n), .irq(irq));

	tps_pin_model MODEL (.clk(clk), .rst(rst), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_lvl(pin_lvl), .drive_lvl(drive_lvl), .per(per), .high(high));

	// ==========
	// checks and bus cycles
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) n_fail++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [2:0] idx, input logic [31:0] d);
		apb({3'b000, idx, 2'b00}, 1'b1, d);
	endtask : wr

	task automatic rchk(input string what, input logic [2:0] idx, input logic [31:0] exp);
		apb({3'b000, idx, 2'b00}, 1'b0, 32'h0000_0000);
		chk(what, rd, exp);
	endtask : rchk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// pin 0 must hold one level for n clocks
	task automatic watch(input logic lvl, input int n);
		bad = 0;
		repeat (n) begin
			@(posedge clk);
			if (pin_out[0] !== lvl) bad++;
		end
		chk("pin0 steady", bad, 0);
	endtask : watch

	task automatic end_of_test;
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		cyc(20000);
		n_fail++;
		end_of_test();
	end

	// ==========
	// tests
	initial begin
		cyc(3);
		rst <= 1'b0;
		rchk("mode", TPS_IDX_MODE, 32'h0000_0000);
		rchk("pending", TPS_IDX_IRQ_PND, 32'h0000_0000);
		apb(8'h20, 1'b0, 32'h0000_0000);
		chk("unmapped", {31'h0, err}, 32'h0000_0001);
		// low-power: control writes land, data writes do not
		wr(TPS_IDX_PER, 32'h0000_0005);
		rchk("lp period", TPS_IDX_PER, 32'h0000_0000);
		wr(TPS_IDX_CNT, 32'h0000_0005);
		rchk("lp counter", TPS_IDX_CNT, 32'h0000_0000);
		wr(TPS_IDX_PSC, 32'h0000_0001);
		rchk("lp prescale", TPS_IDX_PSC, 32'h0000_0001);
		// dual 8-bit, lanes of period 4 and 8
		wr(TPS_IDX_PSC, 32'h0000_0000);
		wr(TPS_IDX_MODE, 32'h0000_0004);
		wr(TPS_IDX_PER, 32'h0000_0703);
		wr(TPS_IDX_DTY, 32'h0000_0201);
		wr(TPS_IDX_MODE, 32'h0000_0007);
		cyc(40);
		chk("lane0 period", per[0], 32'h0000_0004);
		chk("lane0 high", high[0], 32'h0000_0001);
		chk("lane1 period", per[1], 32'h0000_0008);
		chk("lane1 high", high[1], 32'h0000_0002);
		rchk("dual8 pending", TPS_IDX_IRQ_PND, 32'h0000_000F);
		wr(TPS_IDX_MODE, 32'h0000_0004);
		cyc(3);
		chk("stop pins", pin_out, 32'h0000_0000);
		wr(TPS_IDX_IRQ_PND, 32'h0000_000F);
		rchk("cleared", TPS_IDX_IRQ_PND, 32'h0000_0000);
		// 16-bit, prescale 1, pin1 inverted
		wr(TPS_IDX_MODE, 32'h0000_0008);
		wr(TPS_IDX_PSC, 32'h0000_0001);
		wr(TPS_IDX_PER, 32'h0000_0004);
		wr(TPS_IDX_DTY, 32'h0000_0002);
		wr(TPS_IDX_IO_CTL, 32'h0000_0080);
		wr(TPS_IDX_CNT, 32'h0000_0000);
		wr(TPS_IDX_MODE, 32'h0000_0009);
		cyc(60);
		chk("pwm16 period", per[0], 32'h0000_000A);
		chk("pwm16 high", high[0], 32'h0000_0004);
		chk("pins opposed", {31'h0, pin_out[1] ^ pin_out[0]}, 32'h0000_0001);
		wr(TPS_IDX_PER, 32'h0000_0009);
		rchk("period readback", TPS_IDX_PER, 32'h0000_0009);
		cyc(80);
		chk("new period", per[0], 32'h0000_0014);
		wr(TPS_IDX_CNT, 32'h0000_AB00);
		apb({3'b000, TPS_IDX_CNT, 2'b00}, 1'b0, 32'h0000_0000);
		chk("run counter write", {24'h0, rd[15:8]}, 32'h0000_0000);
		wr(TPS_IDX_MODE, 32'h0000_0008);
		cyc(3);
		chk("stop polarity", pin_out, 32'h0000_0002);
		rchk("pwm16 pending", TPS_IDX_IRQ_PND, 32'h0000_0003);
		chk("irq masked", irq, 1'b0);
		wr(TPS_IDX_IRQ_EN, 32'h0000_0001);
		cyc(3);
		chk("irq raised", irq, 1'b1);
		wr(TPS_IDX_MODE, 32'h0000_0000);
		wr(TPS_IDX_IRQ_PND, 32'h0000_0003);
		rchk("lp clear", TPS_IDX_IRQ_PND, 32'h0000_0003);
		wr(TPS_IDX_MODE, 32'h0000_0008);
		wr(TPS_IDX_IRQ_PND, 32'h0000_0003);
		cyc(3);
		chk("irq dropped", irq, 1'b0);
		// zero duty, then duty above period
		wr(TPS_IDX_PSC, 32'h0000_0000);
		wr(TPS_IDX_PER, 32'h0000_0003);
		wr(TPS_IDX_DTY, 32'h0000_0000);
		wr(TPS_IDX_MODE, 32'h0000_0009);
		watch(1'b0, 30);
		wr(TPS_IDX_MODE, 32'h0000_0008);
		wr(TPS_IDX_DTY, 32'h0000_0005);
		wr(TPS_IDX_MODE, 32'h0000_0009);
		cyc(8);
		watch(1'b1, 30);
		// preset above period counts up through FFh and wraps before the first period
		wr(TPS_IDX_MODE, 32'h0000_0004);
		wr(TPS_IDX_DTY, 32'h0000_0002);
		wr(TPS_IDX_CNT, 32'h0000_00F8);
		wr(TPS_IDX_MODE, 32'h0000_0005);
		watch(1'b0, 7);
		cyc(20);
		chk("wrap period", per[0], 32'h0000_0004);
		// capture: pin0 rise clears, pin1 fall 12 clocks later
		wr(TPS_IDX_MODE, 32'h0000_000C);
		wr(TPS_IDX_IO_CTL, {24'h0, 1'b0, TPS_EDG_FALL, 1'b0, TPS_EDG_RISE_CLR});
		drive_lvl <= 2'b10;
		wr(TPS_IDX_CNT, 32'h0000_0000);
		wr(TPS_IDX_IRQ_PND, 32'h0000_000F);
		wr(TPS_IDX_MODE, 32'h0000_000D);
		cyc(5);
		drive_lvl[0] <= 1'b1;
		cyc(12);
		drive_lvl[1] <= 1'b0;
		cyc(5);
		rchk("capture span", TPS_IDX_DTY, 32'h0000_000B);
		rchk("capture pending", TPS_IDX_IRQ_PND, 32'h0000_0003);
		rchk("capture first", TPS_IDX_PER, 32'h0000_0005);
		// pin0 on both edges with clear: a fall restarts the count
		wr(TPS_IDX_IO_CTL, {24'h0, 4'h0, 1'b0, TPS_EDG_BOTH_CLR_B});
		drive_lvl[0] <= 1'b0;
		cyc(4);
		rchk("both-edge clear", TPS_IDX_CNT, 32'h0000_0004);
		// overflow from a preset near the top
		wr(TPS_IDX_MODE, 32'h0000_000C);
		wr(TPS_IDX_CNT, 32'h0000_FFF0);
		wr(TPS_IDX_IRQ_PND, 32'h0000_000F);
		wr(TPS_IDX_MODE, 32'h0000_000D);
		cyc(30);
		rchk("overflow", TPS_IDX_IRQ_PND, 32'h0000_0004);
		// low-power freezes the count
		wr(TPS_IDX_MODE, 32'h0000_0001);
		apb({3'b000, TPS_IDX_CNT, 2'b00}, 1'b0, 32'h0000_0000);
		rd2 = rd;
		cyc(10);
		rchk("frozen", TPS_IDX_CNT, rd2);
		end_of_test();
	end
endmodule : tps_timer_test

`default_nettype wire
